// >>> hdl/sideband_pkg.sv
// Function
// RULE1 - active-low interrupt output for enabled local and remote conditions
// RULE2 - host sets control bits 5 and 0 to enable remote propagation
// RULE3 - propagation enabled: far-end input falling pulls interrupt low
// RULE4 - host reads interrupt status after seeing interrupt output low
// RULE5 - status read clears pending interrupt and releases output high
// RULE6 - after clearing, new remote interrupt only on next far-end fall
// RULE7 - mirror output follows far-end interrupt level, no clearing needed
// RULE8 - mirror output held high while no link exists
// RULE9 - each link io configurable as forward or back channel by register
// RULE10 - code 3 selects forward, code 5 back channel, per documented fields
// RULE11 - local codes: 1 drives low, 9 drives high, 3 input read back
// RULE12 - four register-only ios set or read through local register bits
// RULE13 - enabled register-only io overrides shared audio input on its pin
// RULE14 - register-only io state stays local, not sent across the link
// RULE15 - back-channel samples per frame follow deserializer mode field
// RULE16 - spi pass-through uses secondary lane only, needs two lanes
// RULE17 - forward: spi master here sends downstream; reverse: far end
// RULE18 - spi reads need clock period longer than link round trip
// RULE19 - spi writes may run fast and ignore miso
// RULE20 - back channel runs at 5, 10 or 20 Mbps chosen by deserializer
// RULE21 - after reset interrupt output high and io configs at defaults
package sideband_pkg;
  localparam logic [7:0] OFS_LINK_IO0   = 8'h0d;
  localparam logic [7:0] OFS_LINK_IO12  = 8'h0e;
  localparam logic [7:0] OFS_LINK_IO3   = 8'h0f;
  localparam logic [7:0] OFS_LOCAL_56   = 8'h10;
  localparam logic [7:0] OFS_LOCAL_78   = 8'h11;
  localparam logic [7:0] OFS_IN_LEVELS  = 8'h1c;
  localparam logic [7:0] OFS_IO8_LEVEL  = 8'h1d;
  localparam logic [7:0] OFS_IRQ_CTRL   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h19;
  localparam logic [7:0] OFS_IRQ_CTRL_D = 8'hc6;
  localparam logic [7:0] OFS_IRQ_STAT_D = 8'hc7;
  localparam logic [7:0] OFS_SPI_CTRL   = 8'h1e;
  localparam logic [3:0] CODE_OUT_LOW   = 4'h1;
  localparam logic [3:0] CODE_FWD_IN    = 4'h3;
  localparam logic [3:0] CODE_BACK      = 4'h5;
  localparam logic [3:0] CODE_OUT_HIGH  = 4'h9;
  localparam logic [3:0] CODE_RESET     = 4'h0;
  localparam int         BIT_IRQ_GLOBAL = 0;
  localparam int         BIT_IRQ_REMOTE = 5;
  localparam int         BIT_ST_GLOBAL  = 0;
  localparam int         BIT_ST_REMOTE  = 5;
  localparam int         NUM_LOCAL_SRC  = 4;
  localparam logic [2:0] MODE_NORMAL    = 3'b000;
  localparam logic [2:0] MODE_FAST1     = 3'b001;
  localparam logic [2:0] MODE_FAST2     = 3'b010;
  localparam logic [2:0] MODE_FAST4     = 3'b011;
  localparam logic [3:0] SAMP_NORMAL    = 4'h1;
  localparam logic [3:0] SAMP_FAST4     = 4'h6;
  localparam logic [3:0] SAMP_FAST2     = 4'ha;
  localparam logic [3:0] SAMP_FAST1     = 4'hf;
  localparam logic [2:0] NUM_IO_NORMAL  = 3'h4;
  localparam logic [2:0] NUM_IO_FAST2   = 3'h2;
  localparam logic [2:0] NUM_IO_FAST1   = 3'h1;
  typedef struct packed {
    logic [2:0] io_count;
    logic [3:0] samples;
  } bc_sampling_t;
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] level;
  } io_drive_t;
endpackage : sideband_pkg

// >>> hdl/link_irq_gpio.sv
`timescale 1ns/1ps
module link_irq_gpio #(
  parameter int N_LINK  = 4,
  parameter int N_LOCAL = 4
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic                  i_link_up,
  input  wire logic                  i_two_lane,
  input  wire logic                  i_far_end_irq_in_n,
  input  wire logic [2:0]            i_fast_ctrl_channel_sel,
  input  wire logic [sideband_pkg::NUM_LOCAL_SRC-1:0] i_local_irq,
  output logic                       o_irq_out_n,
  output logic                       o_far_end_irq_mirror,
  input  wire logic [N_LINK-1:0]     i_link_io_pin,
  output logic [N_LINK-1:0]          o_link_io_pin,
  output logic [N_LINK-1:0]          o_link_io_oe,
  output logic [N_LINK-1:0]          o_link_io_fwd_en,
  output logic [N_LINK-1:0]          o_link_io_fwd_val,
  input  wire logic [N_LINK-1:0]     i_link_io_back_val,
  input  wire logic [N_LOCAL-1:0]    i_local_io_pin,
  output logic [N_LOCAL-1:0]         o_local_io_pin,
  output logic [N_LOCAL-1:0]         o_local_io_oe,
  output logic [N_LOCAL-1:0]         o_audio_in_en,
  output logic [2:0]                 o_bc_io_count,
  output logic [3:0]                 o_bc_samples,
  output logic                       o_spi_fwd_active,
  output logic                       o_spi_rev_active
);
  localparam int NUM_SRC = sideband_pkg::NUM_LOCAL_SRC;

  logic [3:0] link_cfg  [N_LINK];
  logic [3:0] local_cfg [N_LOCAL];
  logic [7:0] irq_ctrl_reg;
  logic [7:0] irq_status_reg;
  logic [1:0] spi_ctrl_reg;
  logic [2:0] far_sync_reg;
  logic       far_level_reg;
  logic [N_LINK-1:0]  link_sync1_reg, link_sync2_reg, link_sync3_reg;
  logic [N_LOCAL-1:0] loc_sync1_reg, loc_sync2_reg, loc_sync3_reg;
  logic [N_LINK-1:0]  link_in_reg;
  logic [N_LOCAL-1:0] loc_in_reg;
  logic               far_fall;
  logic               remote_en;
  logic               status_rd;
  logic [NUM_SRC-1:0] local_en;

  // register writes; fields return to parking code after reset
  // RULE21 config defaults
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < N_LINK; k++) link_cfg[k] <= sideband_pkg::CODE_RESET;
      for (int k = 0; k < N_LOCAL; k++)
        local_cfg[k] <= sideband_pkg::CODE_RESET;
      irq_ctrl_reg <= 8'h00;
      spi_ctrl_reg <= 2'b00;
    end else if (i_reg_wr) begin
      // RULE9 RULE10 direction fields
      case (i_reg_addr)
        sideband_pkg::OFS_LINK_IO0:  link_cfg[0] <= i_reg_wdata[3:0];
        sideband_pkg::OFS_LINK_IO12: begin
          link_cfg[1] <= i_reg_wdata[3:0];
          link_cfg[2] <= i_reg_wdata[7:4];
        end
        sideband_pkg::OFS_LINK_IO3:  link_cfg[3] <= i_reg_wdata[3:0];
        // RULE12 local io fields
        sideband_pkg::OFS_LOCAL_56: begin
          local_cfg[0] <= i_reg_wdata[3:0];
          local_cfg[1] <= i_reg_wdata[7:4];
        end
        sideband_pkg::OFS_LOCAL_78: begin
          local_cfg[2] <= i_reg_wdata[3:0];
          local_cfg[3] <= i_reg_wdata[7:4];
        end
        sideband_pkg::OFS_IRQ_CTRL_D: irq_ctrl_reg <= i_reg_wdata;
        sideband_pkg::OFS_SPI_CTRL:   spi_ctrl_reg <= i_reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // pin inputs through three flops, change taken when 2nd and 3rd agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      far_sync_reg   <= 3'b111;
      far_level_reg  <= 1'b1;
      link_sync1_reg <= '0;
      link_sync2_reg <= '0;
      link_sync3_reg <= '0;
      loc_sync1_reg  <= '0;
      loc_sync2_reg  <= '0;
      loc_sync3_reg  <= '0;
      link_in_reg    <= '0;
      loc_in_reg     <= '0;
    end else begin
      far_sync_reg   <= {far_sync_reg[1:0], i_far_end_irq_in_n};
      if (far_sync_reg[1] == far_sync_reg[2]) far_level_reg <= far_sync_reg[2];
      link_sync1_reg <= i_link_io_pin;
      link_sync2_reg <= link_sync1_reg;
      link_sync3_reg <= link_sync2_reg;
      loc_sync1_reg  <= i_local_io_pin;
      loc_sync2_reg  <= loc_sync1_reg;
      loc_sync3_reg  <= loc_sync2_reg;
      for (int k = 0; k < N_LINK; k++)
        if (link_sync2_reg[k] == link_sync3_reg[k])
          link_in_reg[k] <= link_sync3_reg[k];
      for (int k = 0; k < N_LOCAL; k++)
        if (loc_sync2_reg[k] == loc_sync3_reg[k])
          loc_in_reg[k] <= loc_sync3_reg[k];
    end
  end

  // RULE6 edge detect only
  assign far_fall = far_level_reg & (far_sync_reg[1] == far_sync_reg[2])
                    & ~far_sync_reg[2];
  assign remote_en = irq_ctrl_reg[sideband_pkg::BIT_IRQ_REMOTE]
                     & irq_ctrl_reg[sideband_pkg::BIT_IRQ_GLOBAL];
  assign status_rd = i_reg_rd & (i_reg_addr == sideband_pkg::OFS_IRQ_STAT_D);
  assign local_en  = irq_ctrl_reg[NUM_SRC:1] & i_local_irq;

  // sticky status: a new event wins over the clearing read
  // RULE3 RULE5 set and clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_status_reg <= 8'h00;
    end else begin
      if (status_rd) irq_status_reg <= 8'h00;
      if (remote_en && far_fall && i_link_up)
        irq_status_reg[sideband_pkg::BIT_ST_REMOTE] <= 1'b1;
      for (int k = 0; k < NUM_SRC; k++)
        if (irq_ctrl_reg[sideband_pkg::BIT_IRQ_GLOBAL] && local_en[k])
          irq_status_reg[k+1] <= 1'b1;
    end
  end

  // RULE1 RULE21 active-low output
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_irq_out_n <= 1'b1;
    else       o_irq_out_n <= ~(|irq_status_reg);
  end

  // RULE7 RULE8 mirror
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_far_end_irq_mirror <= 1'b1;
    else       o_far_end_irq_mirror <= i_link_up ? far_level_reg : 1'b1;
  end

  // RULE11 local drive codes on link io pins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_link_io_pin     <= '0;
      o_link_io_oe      <= '0;
      o_link_io_fwd_en  <= '0;
      o_link_io_fwd_val <= '0;
    end else begin
      for (int k = 0; k < N_LINK; k++) begin
        o_link_io_fwd_en[k]  <= (link_cfg[k] == sideband_pkg::CODE_FWD_IN);
        o_link_io_fwd_val[k] <= link_in_reg[k];
        case (link_cfg[k])
          sideband_pkg::CODE_OUT_LOW: begin
            o_link_io_oe[k]  <= 1'b1;
            o_link_io_pin[k] <= 1'b0;
          end
          sideband_pkg::CODE_OUT_HIGH: begin
            o_link_io_oe[k]  <= 1'b1;
            o_link_io_pin[k] <= 1'b1;
          end
          // RULE9 back channel drives pin from far end
          sideband_pkg::CODE_BACK: begin
            o_link_io_oe[k]  <= 1'b1;
            o_link_io_pin[k] <= i_link_io_back_val[k];
          end
          default: begin
            o_link_io_oe[k]  <= 1'b0;
            o_link_io_pin[k] <= 1'b0;
          end
        endcase
      end
    end
  end

  // RULE13 RULE14 local io, never forwarded
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_local_io_pin <= '0;
      o_local_io_oe  <= '0;
      o_audio_in_en  <= '1;
    end else begin
      for (int k = 0; k < N_LOCAL; k++) begin
        o_local_io_oe[k]  <= (local_cfg[k] == sideband_pkg::CODE_OUT_LOW)
                           | (local_cfg[k] == sideband_pkg::CODE_OUT_HIGH);
        o_local_io_pin[k] <= (local_cfg[k] == sideband_pkg::CODE_OUT_HIGH);
        o_audio_in_en[k]  <= ~((local_cfg[k] == sideband_pkg::CODE_OUT_LOW)
                           | (local_cfg[k] == sideband_pkg::CODE_OUT_HIGH)
                           | (local_cfg[k] == sideband_pkg::CODE_FWD_IN));
      end
    end
  end

  // RULE15 RULE20 back-channel sampling; rate is set at far end
  sideband_pkg::bc_sampling_t bc_next;
  always_comb begin
    bc_next.io_count = sideband_pkg::NUM_IO_NORMAL;
    bc_next.samples  = sideband_pkg::SAMP_NORMAL;
    case (i_fast_ctrl_channel_sel)
      sideband_pkg::MODE_FAST4: bc_next.samples = sideband_pkg::SAMP_FAST4;
      sideband_pkg::MODE_FAST2: begin
        bc_next.io_count = sideband_pkg::NUM_IO_FAST2;
        bc_next.samples  = sideband_pkg::SAMP_FAST2;
      end
      sideband_pkg::MODE_FAST1: begin
        bc_next.io_count = sideband_pkg::NUM_IO_FAST1;
        bc_next.samples  = sideband_pkg::SAMP_FAST1;
      end
      default: ;
    endcase
  end

  // RULE16 RULE17 spi direction gated on two lanes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bc_io_count    <= sideband_pkg::NUM_IO_NORMAL;
      o_bc_samples     <= sideband_pkg::SAMP_NORMAL;
      o_spi_fwd_active <= 1'b0;
      o_spi_rev_active <= 1'b0;
    end else begin
      o_bc_io_count    <= bc_next.io_count;
      o_bc_samples     <= bc_next.samples;
      o_spi_fwd_active <= i_two_lane & i_link_up & spi_ctrl_reg[0];
      o_spi_rev_active <= i_two_lane & i_link_up & spi_ctrl_reg[1]
                          & ~spi_ctrl_reg[0];
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        sideband_pkg::OFS_LINK_IO0:   o_reg_rdata <= {4'h0, link_cfg[0]};
        sideband_pkg::OFS_LINK_IO12:
          o_reg_rdata <= {link_cfg[2], link_cfg[1]};
        sideband_pkg::OFS_LINK_IO3:   o_reg_rdata <= {4'h0, link_cfg[3]};
        sideband_pkg::OFS_LOCAL_56:
          o_reg_rdata <= {local_cfg[1], local_cfg[0]};
        sideband_pkg::OFS_LOCAL_78:
          o_reg_rdata <= {local_cfg[3], local_cfg[2]};
        // RULE11 RULE12 input levels
        sideband_pkg::OFS_IN_LEVELS:
          o_reg_rdata <= {loc_in_reg[2:0], 1'b0, link_in_reg};
        sideband_pkg::OFS_IO8_LEVEL:  o_reg_rdata <= {7'h00, loc_in_reg[3]};
        sideband_pkg::OFS_IRQ_CTRL_D: o_reg_rdata <= irq_ctrl_reg;
        sideband_pkg::OFS_IRQ_STAT_D: o_reg_rdata <= irq_status_reg;
        sideband_pkg::OFS_SPI_CTRL:   o_reg_rdata <= {6'h00, spi_ctrl_reg};
        default:                      o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // RULE5 clearing read releases output
  property p_read_release;
    @(posedge i_clk) disable iff (i_rst)
    (status_rd && !far_fall && !(|local_en)) |-> ##2 o_irq_out_n;
  endproperty
  chk_read_release: assert property (p_read_release) // RULE5
    else $error("interrupt not released after status read");

  // RULE3 remote event pulls output low
  sequence s_remote_event;
    remote_en && far_fall && i_link_up;
  endsequence
  chk_remote_assert: assert property ( // RULE3
    @(posedge i_clk) disable iff (i_rst)
    s_remote_event ##1 !status_rd |-> ##1 !o_irq_out_n)
    else $error("remote interrupt not signalled");

  // RULE8 mirror high without link
  chk_mirror_nolink: assert property ( // RULE8
    @(posedge i_clk) disable iff (i_rst)
    !i_link_up |=> o_far_end_irq_mirror)
    else $error("mirror low without link");

  // RULE7 mirror tracks far level
  chk_mirror_follow: assert property ( // RULE7
    @(posedge i_clk) disable iff (i_rst)
    i_link_up |=> o_far_end_irq_mirror == $past(far_level_reg))
    else $error("mirror does not follow far input");

  // RULE1 output low only with pending status
  chk_irq_cause: assert property ( // RULE1
    @(posedge i_clk) disable iff (i_rst)
    $fell(o_irq_out_n) |-> $past(|irq_status_reg))
    else $error("interrupt asserted with no cause");

  // RULE6 no remote set without falling edge
  chk_remote_edge: assert property ( // RULE6
    @(posedge i_clk) disable iff (i_rst)
    $rose(irq_status_reg[sideband_pkg::BIT_ST_REMOTE]) |-> $past(far_fall))
    else $error("remote interrupt without falling edge");

  // RULE11 output-high code reaches link io 3 pin
  chk_drive_high: assert property ( // RULE11
    @(posedge i_clk) disable iff (i_rst)
    (link_cfg[3] == sideband_pkg::CODE_OUT_HIGH) ##1
    (link_cfg[3] == sideband_pkg::CODE_OUT_HIGH)
    |-> o_link_io_oe[3] && o_link_io_pin[3])
    else $error("output high code not driven");

  // RULE13 io mode blocks audio input
  chk_audio_override: assert property ( // RULE13
    @(posedge i_clk) disable iff (i_rst)
    (local_cfg[0] == sideband_pkg::CODE_OUT_LOW) |=> !o_audio_in_en[0])
    else $error("audio input not overridden");

  // RULE16 spi needs two lanes
  chk_spi_lanes: assert property ( // RULE16
    @(posedge i_clk) disable iff (i_rst)
    !i_two_lane |=> !o_spi_fwd_active && !o_spi_rev_active)
    else $error("spi active on one lane");
endmodule : link_irq_gpio

// >>> verif/far_end_model.sv
`timescale 1ns/1ps
module far_end_model (
  input  wire logic       i_clk,
  input  wire logic       i_link_req,
  input  wire logic       i_irq_req,
  input  wire logic [2:0] i_mode,
  input  wire logic [3:0] i_back_req,
  output logic            o_link_up,
  output logic            o_irq_n,
  output logic [2:0]      o_mode,
  output logic [3:0]      o_back_val
);
  initial begin
    o_link_up  = 1'b0;
    o_irq_n    = 1'b1;
    o_mode     = 3'h0;
    o_back_val = 4'h0;
  end
  always @(negedge i_clk) begin
    o_link_up <= i_link_req;
    // downstream source release; no link: last level held
    o_irq_n <= i_link_req ? ~i_irq_req : o_irq_n;
    o_mode <= i_mode;
    // no link: back values keep toggling
    o_back_val <= i_link_req ? i_back_req : ~o_back_val;
  end
endmodule : far_end_model

// >>> verif/link_irq_gpio_tb.sv
`timescale 1ns/1ps
module link_irq_gpio_tb;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic       link_req = 1'b0, irq_req = 1'b0, two_lane = 1'b0;
  logic [2:0] mode_req = 3'h0, mode;
  logic [3:0] back_req = 4'h0, back_val, local_irq = 4'h0;
  logic       link_up, far_irq_n, irq_n, mirror, fwd_act, rev_act;
  logic [3:0] lnk_drv = 4'h0, lpin, loe, fwd_en, fwd_val;
  logic [3:0] loc_drv = 4'h0, cpin, coe, audio_en, samp;
  logic [2:0] cnt;
  int         error_cnt = 0, n_checks = 0;
  logic [9:0] tbl [4] = '{10'h041, 10'h1c6, 10'h12a, 10'h09f};
  always #25 clk = ~clk;
  far_end_model u_far_end_model (.i_clk(clk), .i_link_req(link_req),
    .i_irq_req(irq_req), .i_mode(mode_req), .i_back_req(back_req),
    .o_link_up(link_up), .o_irq_n(far_irq_n), .o_mode(mode),
    .o_back_val(back_val));
  link_irq_gpio u_link_irq_gpio (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_link_up(link_up), .i_two_lane(two_lane),
    .i_far_end_irq_in_n(far_irq_n), .i_fast_ctrl_channel_sel(mode),
    .i_local_irq(local_irq), .o_irq_out_n(irq_n),
    .o_far_end_irq_mirror(mirror),
    .i_link_io_pin((loe & lpin) | (~loe & lnk_drv)),
    .o_link_io_pin(lpin), .o_link_io_oe(loe), .o_link_io_fwd_en(fwd_en),
    .o_link_io_fwd_val(fwd_val), .i_link_io_back_val(back_val),
    .i_local_io_pin((coe & cpin) | (~coe & loc_drv)),
    .o_local_io_pin(cpin), .o_local_io_oe(coe), .o_audio_in_en(audio_en),
    .o_bc_io_count(cnt), .o_bc_samples(samp),
    .o_spi_fwd_active(fwd_act), .o_spi_rev_active(rev_act));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rreg
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_irq(input logic lvl);
    repeat (20) if (irq_n !== lvl) @(negedge clk);
    chk({7'h00, irq_n}, {7'h00, lvl});
  endtask : wait_irq
  task automatic t_reset;
    chk({6'h00, irq_n, mirror}, 8'h03);
    rreg(8'h0d);
    chk(d, 8'h00);
    rreg(8'hc6);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_remote;
    link_req = 1'b1;
    wreg(8'hc6, 8'h21);
    irq_req = 1'b1;
    wait_irq(1'b0);
    chk({7'h00, mirror}, 8'h00);
    rreg(8'hc7);
    chk(d & 8'h20, 8'h20);
    cyc(1);
    chk({7'h00, irq_n}, 8'h01);
    cyc(10);
    chk({7'h00, irq_n}, 8'h01);
    irq_req = 1'b0;
    cyc(8);
    chk({6'h00, irq_n, mirror}, 8'h03);
    irq_req = 1'b1;
    wait_irq(1'b0);
    rreg(8'hc7);
    link_req = 1'b0;
    cyc(8);
    chk({7'h00, mirror}, 8'h01);
    irq_req = 1'b0;
    link_req = 1'b1;
    cyc(8);
  endtask : t_remote
  task automatic t_local;
    wreg(8'hc6, 8'h03);
    local_irq = 4'h1;
    cyc(1);
    local_irq = 4'h0;
    wait_irq(1'b0);
    rreg(8'hc7);
    chk(d & 8'h02, 8'h02);
    cyc(1);
    chk({7'h00, irq_n}, 8'h01);
    irq_req = 1'b1;
    cyc(10);
    chk({7'h00, irq_n}, 8'h01);
    irq_req = 1'b0;
  endtask : t_local
  task automatic t_link_io;
    wreg(8'h0d, 8'h03);
    wreg(8'h0e, 8'h53);
    wreg(8'h0f, 8'h09);
    lnk_drv = 4'h1;
    back_req = 4'h4;
    cyc(6);
    chk({fwd_en, loe}, 8'h3c);
    chk({4'h0, lpin & loe}, 8'h0c);
    chk({4'h0, fwd_val & fwd_en}, 8'h01);
    rreg(8'h1c);
    chk(d & 8'h03, 8'h01);
    wreg(8'h0f, 8'h01);
    cyc(3);
    chk({6'h00, loe[3], lpin[3]}, 8'h02);
  endtask : t_link_io
  task automatic t_local_io;
    wreg(8'h10, 8'h91);
    wreg(8'h11, 8'h33);
    loc_drv = 4'hc;
    cyc(6);
    chk({coe, cpin & coe}, 8'h32);
    chk({audio_en, fwd_en}, 8'h03);
    rreg(8'h1c);
    chk(d & 8'h80, 8'h80);
    rreg(8'h1d);
    chk(d & 8'h01, 8'h01);
  endtask : t_local_io
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      mode_req = tbl[i][9:7];
      cyc(4);
      chk({1'b0, cnt, samp}, {1'b0, tbl[i][6:0]});
    end
  endtask : t_modes
  task automatic t_spi;
    // spi clocking is the master's; block only sets direction
    two_lane = 1'b1;
    wreg(8'h1e, 8'h01);
    cyc(2);
    chk({6'h00, fwd_act, rev_act}, 8'h02);
    wreg(8'h1e, 8'h02);
    cyc(2);
    chk({6'h00, fwd_act, rev_act}, 8'h01);
    two_lane = 1'b0;
    cyc(2);
    chk({6'h00, fwd_act, rev_act}, 8'h00);
  endtask : t_spi
  task automatic t_unmapped;
    wreg(8'h55, 8'hff);
    rreg(8'h55);
    chk(d, 8'h00);
  endtask : t_unmapped
  task automatic t_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    t_reset();
  endtask : t_mid_reset
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_remote();
    t_local();
    t_link_io();
    t_local_io();
    t_modes();
    t_spi();
    t_mid_reset();
    t_unmapped();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule : link_irq_gpio_tb
